// >>> include/cssr_pkg.sv
`default_nettype none
package cssr_pkg;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_LP_XTAL = 2'b00,
        SRC_FS_XTAL = 2'b01,
        SRC_RC = 2'b10,
        SRC_EXT = 2'b11
    } cssr_src_t;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_TIMEOUT = 3'b001,
        ST_RIPPLE = 3'b010,
        ST_RUN = 3'b011,
        ST_SLEEP = 3'b100
    } cssr_state_t;

    // ------------------------------------------------------------------
    // fuses: a stored one is unprogrammed, a zero programmed
    // ------------------------------------------------------------------
    localparam logic FUSE_PROGRAMMED = 1'h0;
    localparam logic [3:0] FUSE_SRC_DEFAULT = 4'h2;
    localparam logic [1:0] FUSE_SUT_DEFAULT = 2'h2;
    localparam logic FUSE_DIV8_DEFAULT = 1'h0;
    localparam logic [3:0] DIV8_LOG2 = 4'h3;
    localparam logic [3:0] DIV_LOG2_MAX = 4'h8;

    // ------------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_SRC = 4'h0;
    localparam logic [3:0] REG_PRESCALE = 4'h1;
    localparam logic [3:0] REG_PLL = 4'h2;
    localparam logic [3:0] REG_SLEEP = 4'h3;
    localparam logic [3:0] REG_SLEEP_GO = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_FUSES = 4'h6;
    localparam int SRC_EXT_EN_BIT = 2;
    localparam int PLL_EN_BIT = 0;
    localparam int PLL_DIV_LSB = 1;
    localparam int SLP_STOP_PERIPH_BIT = 0;
    localparam int SLP_STOP_USB_BIT = 1;
    localparam int SLP_OSC_OFF_BIT = 2;
    localparam logic RST_EXT_EN = 1'h1;
    localparam logic RST_PLL_EN = 1'h0;
    localparam logic [2:0] RST_PLL_DIV = 3'h0;
    localparam logic [2:0] RST_SLEEP_CFG = 3'h0;

    // ------------------------------------------------------------------
    // pins, sync order: osc pins by source code, then wdt, reset, wake
    // ------------------------------------------------------------------
    localparam int NUM_OSC_PINS = 5;
    localparam int PIN_WDT = 4;
    localparam int PIN_RST_SRC = 5;
    localparam int PIN_WAKE = 6;
    localparam int NUM_SYNC = 7;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PLL_MULT = 6;
    localparam int PLL_OUT_MHZ = 48;
    localparam int PLL_IN_MHZ = PLL_OUT_MHZ / PLL_MULT;
    localparam int PLL_IN_PERIOD_PS = 1000000 / PLL_IN_MHZ;
    localparam logic [4:0] PLL_PER_LO = 5'(PLL_IN_PERIOD_PS / CLK_PERIOD_PS);
    localparam logic [4:0] PLL_PER_HI =
        5'((PLL_IN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [2:0] PLL_LOCK_TICKS = 3'h4;
    localparam logic [15:0] TOUT_SHORT = 16'h0200;
    localparam logic [15:0] TOUT_LONG = 16'h2000;
    localparam logic [15:0] RIP_6 = 16'h0006;
    localparam logic [15:0] RIP_258 = 16'h0102;
    localparam logic [15:0] RIP_1K = 16'h0400;
    localparam logic [15:0] RIP_16K = 16'h4000;
    localparam logic [15:0] RIP_32K = 16'h8000;
    localparam logic [15:0] RESET_EXTRA_CK = 16'h000E;

endpackage
`default_nettype wire

// >>> rtl/cssr_clock_control.sv
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cssr_clock_control #(
    parameter logic [3:0] SOURCE_SELECT_FUSES = cssr_pkg::FUSE_SRC_DEFAULT,
    parameter logic [1:0] STARTUP_LENGTH_FUSES = cssr_pkg::FUSE_SUT_DEFAULT,
    parameter logic DIVIDE_BY_EIGHT_FUSE = cssr_pkg::FUSE_DIV8_DEFAULT,
    parameter logic [15:0] TIMEOUT_SHORT_CYC = cssr_pkg::TOUT_SHORT,
    parameter logic [15:0] TIMEOUT_LONG_CYC = cssr_pkg::TOUT_LONG
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic [cssr_pkg::NUM_OSC_PINS-1:0] oscPins,
    input wire logic resetSourcesPin,
    input wire logic asyncWakePin,
    output logic internalReset,
    output logic coreClkTick,
    output logic periphClkTick,
    output logic nvmClkTick,
    output logic usbClkEnable,
    output logic extClkEnable
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        cssr_pkg::cssr_state_t state;
        logic [15:0] cnt;
        logic fromReset;
        cssr_pkg::cssr_src_t srcAct;
        cssr_pkg::cssr_src_t srcReq;
        logic [3:0] divAct;
        logic [3:0] divReq;
        logic extEn;
        logic pllEn;
        logic [2:0] pllDiv;
        logic [2:0] sleepCfg;
        logic [4:0] pllPer;
        logic [2:0] pllGood;
        logic pllLock;
        logic [7:0] rdData;
        logic coreTick;
        logic periphTick;
        logic nvmTick;
        logic usbEn;
        logic intRst;
    } cssr_ctl_t;

    // ------------------------------------------------------------------
    // fuse decoding
    // ------------------------------------------------------------------
    // reserved codes fall back to the rc oscillator, which always starts
    function automatic cssr_pkg::cssr_src_t srcOfFuse(input logic [3:0] f);
        if (f[3]) begin
            srcOfFuse = cssr_pkg::SRC_LP_XTAL;
        end else if (f[3:1] == 3'h3) begin
            srcOfFuse = cssr_pkg::SRC_FS_XTAL;
        end else if (f == 4'h0) begin
            srcOfFuse = cssr_pkg::SRC_EXT;
        end else begin
            srcOfFuse = cssr_pkg::SRC_RC;
        end
    endfunction

    function automatic logic [15:0] timeoutLen(input logic [3:0] f,
            input logic [1:0] s);
        logic [2:0] key;
        key = {f[0], s};
        if (srcOfFuse(f) == cssr_pkg::SRC_RC
                || srcOfFuse(f) == cssr_pkg::SRC_EXT) begin
            case (s)
                2'h0: timeoutLen = 16'h0000;
                2'h1: timeoutLen = TIMEOUT_SHORT_CYC;
                default: timeoutLen = TIMEOUT_LONG_CYC;
            endcase
        end else begin
            case (key)
                3'h2, 3'h5: timeoutLen = 16'h0000;
                3'h0, 3'h3, 3'h6: timeoutLen = TIMEOUT_SHORT_CYC;
                default: timeoutLen = TIMEOUT_LONG_CYC;
            endcase
        end
    endfunction

    function automatic logic [15:0] rippleLen(input logic [3:0] f,
            input logic [1:0] s);
        logic [2:0] key;
        key = {f[0], s};
        if (srcOfFuse(f) == cssr_pkg::SRC_RC
                || srcOfFuse(f) == cssr_pkg::SRC_EXT) begin
            rippleLen = cssr_pkg::RIP_6;
        end else if (key < 3'h2) begin
            rippleLen = cssr_pkg::RIP_258;
        end else if (key < 3'h5) begin
            rippleLen = cssr_pkg::RIP_1K;
        end else if (f[3:1] == 3'h4) begin
            rippleLen = cssr_pkg::RIP_32K;
        end else begin
            rippleLen = cssr_pkg::RIP_16K;
        end
    endfunction

    // ------------------------------------------------------------------
    // constants fixed by the fuses
    // ------------------------------------------------------------------
    localparam cssr_pkg::cssr_src_t FUSE_SRC = srcOfFuse(SOURCE_SELECT_FUSES);
    localparam logic [15:0] FUSE_TOUT =
        timeoutLen(SOURCE_SELECT_FUSES, STARTUP_LENGTH_FUSES);
    localparam logic [15:0] FUSE_RIPPLE =
        rippleLen(SOURCE_SELECT_FUSES, STARTUP_LENGTH_FUSES);
    // a programmed (zero) fuse turns the divide-by-eight on
    localparam logic [3:0] FUSE_DIV =
        (DIVIDE_BY_EIGHT_FUSE == cssr_pkg::FUSE_PROGRAMMED)
        ? cssr_pkg::DIV8_LOG2 : 4'h0;

    localparam cssr_ctl_t CTL_RESET = '{
        state: cssr_pkg::ST_HOLD, cnt: 16'h0000, fromReset: 1'b1,
        srcAct: FUSE_SRC, srcReq: FUSE_SRC, divAct: FUSE_DIV,
        divReq: FUSE_DIV, extEn: cssr_pkg::RST_EXT_EN,
        pllEn: cssr_pkg::RST_PLL_EN, pllDiv: cssr_pkg::RST_PLL_DIV,
        sleepCfg: cssr_pkg::RST_SLEEP_CFG, pllPer: 5'h00,
        pllGood: 3'h0, pllLock: 1'b0, rdData: 8'h00, coreTick: 1'b0,
        periphTick: 1'b0, nvmTick: 1'b0, usbEn: 1'b0, intRst: 1'b1};

    initial begin
        if (TIMEOUT_SHORT_CYC == 16'h0000
                || TIMEOUT_LONG_CYC == 16'h0000) begin
            $error("cssr_clock_control: time-out lengths must be nonzero");
        end
    end

    cssr_ctl_t ctl_ff;
    cssr_ctl_t nxt_ctl;

    // ------------------------------------------------------------------
    // pin synchronisers and dividers
    // ------------------------------------------------------------------
    logic [cssr_pkg::NUM_SYNC-1:0] pinLevel;
    logic [cssr_pkg::NUM_SYNC-1:0] pinRise;
    logic oscStopped;
    logic srcTick;
    logic sysTick;
    logic pllInTick;
    logic switchPending;
    logic applySwitch;
    logic rstSrc;
    logic [15:0] rippleTarget;

    cssr_sync #(
        .WIDTH(cssr_pkg::NUM_SYNC)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .rawIn({asyncWakePin, resetSourcesPin, oscPins}),
        .level(pinLevel),
        .rise(pinRise)
    );

    assign rstSrc = pinLevel[cssr_pkg::PIN_RST_SRC];
    // oscillators stop only in the deep sleep that asks for it
    assign oscStopped = ctl_ff.state == cssr_pkg::ST_SLEEP
        && ctl_ff.sleepCfg[cssr_pkg::SLP_OSC_OFF_BIT];
    assign srcTick = pinRise[ctl_ff.srcAct] && !oscStopped;
    assign switchPending = ctl_ff.srcReq != ctl_ff.srcAct
        || ctl_ff.divReq != ctl_ff.divAct;
    // changes land on a divided period boundary, or at once while in internal reset, so no short pulse
    assign applySwitch = switchPending
        && (sysTick || ctl_ff.intRst);

    cssr_prescaler #(
        .CNT_W(8)
    ) u_sys_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .restart(applySwitch),
        .inTick(srcTick),
        .log2Div(ctl_ff.divAct),
        .outTick(sysTick)
    );

    cssr_prescaler #(
        .CNT_W(8)
    ) u_pll_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .restart(!ctl_ff.pllEn),
        .inTick(srcTick),
        .log2Div({1'b0, ctl_ff.pllDiv}),
        .outTick(pllInTick)
    );

    assign rippleTarget = FUSE_RIPPLE
        + (ctl_ff.fromReset ? cssr_pkg::RESET_EXTRA_CK : 16'h0000);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_ctl = ctl_ff;
        // start-up sequence
        case (ctl_ff.state)
            cssr_pkg::ST_HOLD: begin
                nxt_ctl.cnt = 16'h0000;
                nxt_ctl.fromReset = 1'b1;
                if (!rstSrc) begin
                    nxt_ctl.state = (FUSE_TOUT == 16'h0000)
                        ? cssr_pkg::ST_RIPPLE
                        : cssr_pkg::ST_TIMEOUT;
                end
            end
            cssr_pkg::ST_TIMEOUT: begin
                if (pinRise[cssr_pkg::PIN_WDT]) begin
                    nxt_ctl.cnt = ctl_ff.cnt + 16'h0001;
                    if (ctl_ff.cnt + 16'h0001 == FUSE_TOUT) begin
                        nxt_ctl.cnt = 16'h0000;
                        nxt_ctl.state = cssr_pkg::ST_RIPPLE;
                    end
                end
            end
            cssr_pkg::ST_RIPPLE: begin
                if (srcTick) begin
                    nxt_ctl.cnt = ctl_ff.cnt + 16'h0001;
                    if (ctl_ff.cnt + 16'h0001 == rippleTarget) begin
                        nxt_ctl.cnt = 16'h0000;
                        nxt_ctl.state = cssr_pkg::ST_RUN;
                    end
                end
            end
            cssr_pkg::ST_RUN: begin
                if (regWr && regAddr == cssr_pkg::REG_SLEEP_GO) begin
                    nxt_ctl.state = cssr_pkg::ST_SLEEP;
                end
            end
            cssr_pkg::ST_SLEEP: begin
                // wake pin is seen even with every gated clock stopped
                if (pinRise[cssr_pkg::PIN_WAKE]) begin
                    nxt_ctl.fromReset = 1'b0;
                    nxt_ctl.cnt = 16'h0000;
                    nxt_ctl.state = ctl_ff.sleepCfg[cssr_pkg::SLP_OSC_OFF_BIT]
                        ? cssr_pkg::ST_RIPPLE
                        : cssr_pkg::ST_RUN;
                end
            end
            default: begin
                nxt_ctl.state = cssr_pkg::ST_HOLD;
            end
        endcase
        if (rstSrc) begin
            nxt_ctl.state = cssr_pkg::ST_HOLD;
        end
        nxt_ctl.intRst = nxt_ctl.state != cssr_pkg::ST_RUN
            && nxt_ctl.state != cssr_pkg::ST_SLEEP;

        // register writes
        if (regWr) begin
            case (regAddr)
                cssr_pkg::REG_SRC: begin
                    nxt_ctl.srcReq =
                        cssr_pkg::cssr_src_t'(regWrData[1:0]);
                    nxt_ctl.extEn = regWrData[cssr_pkg::SRC_EXT_EN_BIT];
                end
                cssr_pkg::REG_PRESCALE: begin
                    nxt_ctl.divReq = (regWrData[3:0] > cssr_pkg::DIV_LOG2_MAX)
                        ? cssr_pkg::DIV_LOG2_MAX : regWrData[3:0];
                end
                cssr_pkg::REG_PLL: begin
                    nxt_ctl.pllEn = regWrData[cssr_pkg::PLL_EN_BIT];
                    nxt_ctl.pllDiv =
                        regWrData[cssr_pkg::PLL_DIV_LSB +: 3];
                end
                cssr_pkg::REG_SLEEP: begin
                    nxt_ctl.sleepCfg = regWrData[2:0];
                end
                default: begin
                end
            endcase
        end
        if (applySwitch) begin
            nxt_ctl.srcAct = ctl_ff.srcReq;
            nxt_ctl.divAct = ctl_ff.divReq;
        end

        // pll lock: input period must sit at the 8 MHz figure
        if (!ctl_ff.pllEn) begin
            nxt_ctl.pllPer = 5'h00;
            nxt_ctl.pllGood = 3'h0;
            nxt_ctl.pllLock = 1'b0;
        end else if (pllInTick) begin
            nxt_ctl.pllPer = 5'h01;
            if (ctl_ff.pllPer >= cssr_pkg::PLL_PER_LO
                    && ctl_ff.pllPer <= cssr_pkg::PLL_PER_HI) begin
                if (ctl_ff.pllGood != cssr_pkg::PLL_LOCK_TICKS) begin
                    nxt_ctl.pllGood = ctl_ff.pllGood + 3'h1;
                end
            end else begin
                nxt_ctl.pllGood = 3'h0;
            end
            nxt_ctl.pllLock = nxt_ctl.pllGood == cssr_pkg::PLL_LOCK_TICKS;
        end else if (ctl_ff.pllPer != 5'h1F) begin
            nxt_ctl.pllPer = ctl_ff.pllPer + 5'h01;
        end

        // gated domain ticks
        nxt_ctl.coreTick = sysTick
            && ctl_ff.state == cssr_pkg::ST_RUN;
        nxt_ctl.nvmTick = nxt_ctl.coreTick;
        nxt_ctl.periphTick = sysTick && (ctl_ff.state == cssr_pkg::ST_RUN
            || (ctl_ff.state == cssr_pkg::ST_SLEEP
            && !ctl_ff.sleepCfg[cssr_pkg::SLP_STOP_PERIPH_BIT]));
        nxt_ctl.usbEn = ctl_ff.pllLock && !ctl_ff.intRst
            && !(ctl_ff.state == cssr_pkg::ST_SLEEP
            && ctl_ff.sleepCfg[cssr_pkg::SLP_STOP_USB_BIT]);

        // read data, one cycle after the strobe
        nxt_ctl.rdData = 8'h00;
        if (regRd) begin
            case (regAddr)
                cssr_pkg::REG_SRC:
                    nxt_ctl.rdData = {5'h00, ctl_ff.extEn, ctl_ff.srcReq};
                cssr_pkg::REG_PRESCALE:
                    nxt_ctl.rdData = {4'h0, ctl_ff.divReq};
                cssr_pkg::REG_PLL:
                    nxt_ctl.rdData = {4'h0, ctl_ff.pllDiv, ctl_ff.pllEn};
                cssr_pkg::REG_SLEEP:
                    nxt_ctl.rdData = {5'h00, ctl_ff.sleepCfg};
                cssr_pkg::REG_STATUS:
                    nxt_ctl.rdData = {ctl_ff.state, ctl_ff.pllLock,
                        switchPending, ctl_ff.srcAct, 1'b0};
                cssr_pkg::REG_FUSES:
                    nxt_ctl.rdData = {1'b0, DIVIDE_BY_EIGHT_FUSE,
                        STARTUP_LENGTH_FUSES, SOURCE_SELECT_FUSES};
                default:
                    nxt_ctl.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl_ff <= CTL_RESET;
        end else begin
            ctl_ff <= nxt_ctl;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign regRdData = ctl_ff.rdData;
    assign internalReset = ctl_ff.intRst;
    assign coreClkTick = ctl_ff.coreTick;
    assign periphClkTick = ctl_ff.periphTick;
    assign nvmClkTick = ctl_ff.nvmTick;
    assign usbClkEnable = ctl_ff.usbEn;
    // firmware may drop the external clock during usb suspend
    assign extClkEnable = ctl_ff.extEn && !oscStopped;

endmodule
`default_nettype wire

// >>> rtl/cssr_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module cssr_prescaler #(
    parameter int CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic restart,
    input wire logic inTick,
    input wire logic [3:0] log2Div,
    output logic outTick
);

    // ------------------------------------------------------------------
    // power-of-two divider of source edges
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } cssr_presc_t;

    cssr_presc_t pr_ff;
    cssr_presc_t nxt_pr;
    logic [CNT_W-1:0] mask;

    initial begin
        if (CNT_W < 8 || CNT_W > 15) begin
            $error("cssr_prescaler: CNT_W must be 8 to 15");
        end
    end

    function automatic logic [CNT_W-1:0] divMask(input logic [3:0] l2);
        logic [CNT_W:0] one;
        one = (CNT_W+1)'(1);
        divMask = CNT_W'((one << l2) - one);
    endfunction

    assign mask = divMask(log2Div);
    // pulse on the last source edge of each divided period
    assign outTick = inTick && ((pr_ff.cnt & mask) == mask);

    always_comb begin
        nxt_pr = pr_ff;
        if (restart) begin
            nxt_pr.cnt = '0;
        end else if (inTick) begin
            nxt_pr.cnt = pr_ff.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pr_ff <= '0;
        end else begin
            pr_ff <= nxt_pr;
        end
    end

endmodule
`default_nettype wire

// >>> rtl/cssr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cssr_sync #(
    parameter int WIDTH = 7
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] rawIn,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);

    // ------------------------------------------------------------------
    // two-flop synchroniser, edge taken after the second flop only
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] last;
    } cssr_sync_t;

    cssr_sync_t sy_ff;
    cssr_sync_t nxt_sy;

    initial begin
        if (WIDTH < 1) begin
            $error("cssr_sync: WIDTH must be at least 1");
        end
    end

    always_comb begin
        nxt_sy.meta = rawIn;
        nxt_sy.sync = sy_ff.meta;
        nxt_sy.last = sy_ff.sync;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sy_ff <= '0;
        end else begin
            sy_ff <= nxt_sy;
        end
    end

    assign level = sy_ff.sync;
    assign rise = sy_ff.sync & ~sy_ff.last;

endmodule
`default_nettype wire

// >>> verif/cssr_clock_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cssr_clock_control_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic resetSourcesPin,
    input wire logic internalReset,
    input wire logic coreClkTick,
    input wire logic periphClkTick,
    input wire logic nvmClkTick,
    input wire logic usbClkEnable,
    input wire logic extClkEnable
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    chk_nvm_core_pair: assert property (
        nvmClkTick == coreClkTick) else $error("nvm tick differs");
    chk_core_halt_reset: assert property (
        internalReset && $past(internalReset) |-> !coreClkTick)
        else $error("core tick in reset");
    chk_periph_halt_reset: assert property (
        internalReset && $past(internalReset) |-> !periphClkTick)
        else $error("periph tick in reset");
    chk_usb_off_reset: assert property (
        internalReset && $past(internalReset) |-> !usbClkEnable)
        else $error("usb clock in reset");
    chk_tick_no_runt: assert property (
        coreClkTick |=> !coreClkTick) else $error("core tick too long");
    chk_reset_src_hold: assert property (
        resetSourcesPin [*5] |-> internalReset)
        else $error("reset released early");
    chk_rd_idle_zero: assert property (
        !regRd |=> regRdData == 8'h00) else $error("read data not idle");
    chk_ext_en_write: assert property (
        regWr && regAddr == cssr_pkg::REG_SRC && !internalReset |=>
        extClkEnable == $past(regWrData[cssr_pkg::SRC_EXT_EN_BIT]))
        else $error("ext enable not written");
endmodule
bind cssr_clock_control cssr_clock_control_chk cssr_clock_control_chk_i (
    .clk_sys, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .resetSourcesPin, .internalReset, .coreClkTick, .periphClkTick,
    .nvmClkTick, .usbClkEnable, .extClkEnable);
`default_nettype wire

// >>> verif/cssr_clock_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cssr_clock_control_tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic resetSourcesPin = 1'b0, asyncWakePin = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic [4:0] oscPins;
    logic internalReset, coreClkTick, periphClkTick, nvmClkTick;
    logic usbClkEnable, extClkEnable;
    int n_fail = 0, compares = 0, cyc = 0;
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    // time-out left on, only shortened to keep the run brief
    cssr_clock_control #(.TIMEOUT_SHORT_CYC(16'h0004),
        .TIMEOUT_LONG_CYC(16'h0008)) cssr_clock_control_i (.clk_sys, .rst,
        .regAddr, .regWrData, .regWr, .regRd, .regRdData, .oscPins,
        .resetSourcesPin, .asyncWakePin, .internalReset, .coreClkTick,
        .periphClkTick, .nvmClkTick, .usbClkEnable, .extClkEnable);
    cssr_osc_model cssr_osc_model_i (.extClkEnable, .oscPins);
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %0h got %0h", n, e, s);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk("regRdData", 16'(e), 16'(regRdData & m));
    endtask
    task automatic wtick();
        int k;
        k = 0;
        @(posedge clk_sys);
        #1;
        while (coreClkTick !== 1'b1 && k < 5000) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
    endtask
    // first tick after a change may still use the old divide
    task automatic per(int e);
        int t0;
        wtick();
        wtick();
        t0 = cyc;
        wtick();
        chk("tickPeriod", 16'(e), 16'(cyc - t0));
    endtask
    task automatic nap(logic [7:0] cfg, output int nc, output int np);
        wr(cssr_pkg::REG_SLEEP, cfg);
        wr(cssr_pkg::REG_SLEEP_GO, 8'h01);
        nc = 0;
        np = 0;
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            nc += int'(coreClkTick);
            np += int'(periphClkTick);
        end
    endtask
    task automatic wake();
        @(posedge clk_sys);
        asyncWakePin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        asyncWakePin <= 1'b0;
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        int nc, np;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (360) @(posedge clk_sys);
        #1 chk("internalReset", 16'h0001, 16'(internalReset));
        repeat (100) @(posedge clk_sys);
        #1 chk("internalReset", 16'h0000, 16'(internalReset));
        $display("test startup done");
        rd(cssr_pkg::REG_FUSES, 8'h22);
        rd(cssr_pkg::REG_SRC, 8'h06);
        rd(cssr_pkg::REG_PRESCALE, 8'h03);
        wr(cssr_pkg::REG_STATUS, 8'hFF);
        rd(cssr_pkg::REG_STATUS, 8'h64);
        rd(4'h7, 8'h00);
        $display("test registers done");
        per(128);
        wr(cssr_pkg::REG_PRESCALE, 8'h00);
        per(16);
        wr(cssr_pkg::REG_PRESCALE, 8'h09);
        per(4096);
        wr(cssr_pkg::REG_PRESCALE, 8'h00);
        wr(cssr_pkg::REG_PLL, 8'h01);
        repeat (150) @(posedge clk_sys);
        #1 chk("usbClkEnable", 16'h0001, 16'(usbClkEnable));
        $display("test prescale and pll done");
        wr(cssr_pkg::REG_SRC, 8'h07);
        per(8);
        rd(cssr_pkg::REG_STATUS, 8'h66, 8'hEF);
        chk("usbClkEnable", 16'h0000, 16'(usbClkEnable));
        wr(cssr_pkg::REG_PLL, 8'h03);
        repeat (150) @(posedge clk_sys);
        #1 chk("usbClkEnable", 16'h0001, 16'(usbClkEnable));
        $display("test source switch done");
        for (int m = 0; m < 2; m++) begin
            nap(8'(m), nc, np);
            chk("coreInSleep", 16'h0000, 16'(nc));
            chk("periphInSleep", 16'(m == 0), 16'(np != 0));
            wake();
            rd(cssr_pkg::REG_STATUS, 8'h60, 8'hE0);
        end
        nap(8'h02, nc, np);
        chk("usbInSleep", 16'h0000, 16'(usbClkEnable));
        wake();
        nap(8'h04, nc, np);
        chk("extClkEnable", 16'h0000, 16'(extClkEnable));
        wake();
        repeat (66) @(posedge clk_sys);
        rd(cssr_pkg::REG_STATUS, 8'h60, 8'hE0);
        $display("test sleep done");
        @(posedge clk_sys);
        resetSourcesPin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 chk("internalReset", 16'h0001, 16'(internalReset));
        $display("test reset source done");
        final_report();
    end
endmodule
`default_nettype wire

// >>> verif/cssr_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module cssr_osc_model (
    input wire logic extClkEnable,
    output logic [4:0] oscPins
);
    // ----------------------------------------
    // sources: lp, fs, rc 8 MHz, ext, watchdog
    // ----------------------------------------
    localparam int HALF [5] = '{200, 100, 64, 32, 40};
    initial oscPins = 5'h00;
    for (genvar g = 0; g < 5; g++) begin : gen_osc
        // external clock stops while disabled, as in usb suspend
        always #(HALF[g])
            oscPins[g] = ~oscPins[g] & (g != 3 | extClkEnable);
    end
endmodule
`default_nettype wire
